// ===== rtl/relay_cfg_pkg.sv
// package: register map, field positions, reset values and timing counts
package relay_cfg_pkg;
    // ************************************************************
    // register map
    // ************************************************************
    localparam logic [3:0] ADDR_OUT_FUNC = 4'h0;
    localparam logic [3:0] ADDR_IND_MODE = 4'h1;
    localparam logic [3:0] ADDR_IRQ_STATUS = 4'h2;
    localparam logic [3:0] ADDR_IRQ_MASK = 4'h3;
    localparam logic [3:0] ADDR_STATE = 4'h4;
    localparam logic [3:0] ADDR_UNLATCH = 4'h5;
    localparam logic [7:0] OUT_FUNC_RST = 8'h00;
    localparam logic [6:0] IND_MODE_RST = 7'h00;
    localparam logic [3:0] IRQ_MASK_RST = 4'h0;
    // ************************************************************
    // fields of output_function_switches
    // ************************************************************
    localparam int SW_LATCH1 = 0;
    localparam int SW_LATCH2 = 1;
    localparam int SW_LATCH3 = 2;
    localparam int SW_SIG_PULSE = 3;
    localparam int SW_TRIP_PULSE = 4;
    localparam int SW_BRK_FAIL = 5;
    localparam int SW_LOCKOUT = 6;
    localparam int SW_EXT_WARN = 7;
    // ************************************************************
    // interrupt status bits
    // ************************************************************
    localparam int IRQ_TRIP = 0;
    localparam int IRQ_BRK_FAIL = 1;
    localparam int IRQ_START = 2;
    localparam int IRQ_WARN = 3;
    // ************************************************************
    // timing
    // ************************************************************
    localparam int CLK_MHZ = 250;
    localparam int TICK_US = 1000;
    localparam int TICK_CYCLES = TICK_US * CLK_MHZ;
    localparam int PULSE_LONG_MS = 80;
    localparam int PULSE_SHORT_MS = 40;
    localparam int TICK_W = 17;
endpackage : relay_cfg_pkg

// ===== rtl/tick_gen.sv
// tick generator: one-cycle pulse every tick period
`timescale 1ns/10ps
module tick_gen #(
    parameter int CYCLES = relay_cfg_pkg::TICK_CYCLES
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    // tick pulse
    output logic tick_o
);
    logic [31:0] cnt_q;

    // free running divider
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cnt_q <= 32'h0000_0000;
            tick_o <= 1'b0;
        end else if (cnt_q == 32'(CYCLES - 1)) begin
            cnt_q <= 32'h0000_0000;
            tick_o <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 32'h0000_0001;
            tick_o <= 1'b0;
        end
    end
endmodule : tick_gen

// ===== rtl/pulse_stretch.sv
// pulse stretcher: holds output for a minimum number of ticks
`timescale 1ns/10ps
module pulse_stretch #(
    parameter int TW = relay_cfg_pkg::TICK_W
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    // control
    input wire logic tick_i,
    input wire logic short_i,
    input wire logic req_i,
    // stretched level
    output logic out_o
);
    logic [TW-1:0] left_q;
    logic req_q;

    // load on rising request, count down in ticks
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            left_q <= '0;
            req_q <= 1'b0;
        end else begin
            req_q <= req_i;
            if (req_i && !req_q) begin
                left_q <= short_i ? TW'(relay_cfg_pkg::PULSE_SHORT_MS)
                                  : TW'(relay_cfg_pkg::PULSE_LONG_MS);
            end else if (tick_i && left_q != '0) begin
                left_q <= left_q - TW'(1);
            end
        end
    end

    assign out_o = req_i || (left_q != '0);
endmodule : pulse_stretch

// ===== rtl/relay_output_config_logic.sv
// relay output configuration, latching, pulse stretch and indications
`timescale 1ns/10ps
module relay_output_config_logic #(
    parameter int TICK_CYCLES = relay_cfg_pkg::TICK_CYCLES,
    parameter int BF_W = 16
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    // register port
    input wire logic [3:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    // trip causes and functions
    input wire logic [2:0] trip_req_i,
    input wire logic lockout_req_i,
    input wire logic [BF_W-1:0] brk_fail_ticks_i,
    // unlatch sources
    input wire logic unlatch_panel_i,
    input wire logic unlatch_din_i,
    input wire logic unlatch_bus_i,
    // signal output requests and warnings
    input wire logic [4:0] sig_req_i,
    input wire logic circuit_warn_i,
    input wire logic light_warn_i,
    // stage starts and phases
    input wire logic [6:0] stage_start_i,
    input wire logic [2:0] phase_i,
    // contacts
    output logic [2:0] trip_o,
    output logic [4:0] sig_o,
    // indications
    output logic [6:0] ind_o,
    output logic [11:0] phase_show_o,
    output logic irq_o
);
    // ************************************************************
    // registers
    // ************************************************************
    logic [7:0] out_func_q;
    logic [6:0] ind_mode_q;
    logic [3:0] irq_stat_q;
    logic [3:0] irq_mask_q;
    logic [2:0] latch_q;
    logic [6:0] ind_q;
    logic [11:0] phase_q;
    logic [BF_W-1:0] bf_cnt_q;
    logic bf_trip_q;
    logic tick;
    logic unlatch;
    logic [2:0] trip_src;
    logic [2:0] trip_str;
    logic [4:0] sig_src;
    logic [4:0] sig_str;
    logic [3:0] ev;
    logic [2:0] trip_prev_q;
    logic [6:0] start_prev_q;

    tick_gen #(
        .CYCLES(TICK_CYCLES)
    ) i_tick_gen (
        .ref_clk_i(ref_clk_i),
        .nrst_i(nrst_i),
        .tick_o(tick)
    );

    // software writes to switch and mask registers
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            out_func_q <= relay_cfg_pkg::OUT_FUNC_RST;
            ind_mode_q <= relay_cfg_pkg::IND_MODE_RST;
            irq_mask_q <= relay_cfg_pkg::IRQ_MASK_RST;
        end else if (wr_i) begin
            case (addr_i)
                relay_cfg_pkg::ADDR_OUT_FUNC: out_func_q <= wdata_i[7:0];
                relay_cfg_pkg::ADDR_IND_MODE: ind_mode_q <= wdata_i[6:0];
                relay_cfg_pkg::ADDR_IRQ_MASK: irq_mask_q <= wdata_i[3:0];
                default: ;
            endcase
        end
    end

    // unlatch from panel, digital input or bus register write
    assign unlatch = unlatch_panel_i || unlatch_din_i || unlatch_bus_i ||
        (wr_i && addr_i == relay_cfg_pkg::ADDR_UNLATCH &&
         wdata_i[0]);

    // ************************************************************
    // breaker failure timer
    // ************************************************************
    // counts ticks while first trip persists, then drives second output
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            bf_cnt_q <= '0;
            bf_trip_q <= 1'b0;
        end else if (!out_func_q[relay_cfg_pkg::SW_BRK_FAIL] ||
                     !trip_req_i[0]) begin
            bf_cnt_q <= '0;
            bf_trip_q <= 1'b0;
        end else if (bf_cnt_q >= brk_fail_ticks_i) begin
            bf_trip_q <= 1'b1;
        end else if (tick) begin
            bf_cnt_q <= bf_cnt_q + BF_W'(1);
        end
    end

    // trip sources; third output dedicated to lockout when selected
    assign trip_src[0] = trip_req_i[0];
    assign trip_src[1] = trip_req_i[1] || bf_trip_q;
    assign trip_src[2] = out_func_q[relay_cfg_pkg::SW_LOCKOUT] ?
        lockout_req_i : trip_req_i[2];

    // ************************************************************
    // trip outputs: latch or stretch
    // ************************************************************
    // latch holds until unlatch, new trip wins over unlatch
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            latch_q <= 3'h0;
        end else begin
            for (int i = 0; i < 3; i++) begin
                if (trip_src[i] && out_func_q[i]) begin
                    latch_q[i] <= 1'b1;
                end else if (unlatch || !out_func_q[i]) begin
                    latch_q[i] <= 1'b0;
                end
            end
        end
    end

    for (genvar g = 0; g < 3; g++) begin : g_trip
        pulse_stretch i_pulse_stretch (
            .ref_clk_i(ref_clk_i),
            .nrst_i(nrst_i),
            .tick_i(tick),
            .short_i(out_func_q[relay_cfg_pkg::SW_TRIP_PULSE]),
            .req_i(trip_src[g]),
            .out_o(trip_str[g])
        );
    end

    // registered contacts
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            trip_o <= 3'h0;
        end else begin
            for (int i = 0; i < 3; i++) begin
                // latched mode ignores stretching
                trip_o[i] <= out_func_q[i] ? (latch_q[i] || trip_src[i])
                                           : trip_str[i];
            end
        end
    end

    // ************************************************************
    // signal outputs
    // ************************************************************
    assign sig_src[0] = sig_req_i[0];
    assign sig_src[1] = sig_req_i[1] ||
        (out_func_q[relay_cfg_pkg::SW_EXT_WARN] &&
         (circuit_warn_i || light_warn_i));
    assign sig_src[4:2] = sig_req_i[4:2];

    for (genvar g = 0; g < 5; g++) begin : g_sig
        pulse_stretch i_pulse_stretch (
            .ref_clk_i(ref_clk_i),
            .nrst_i(nrst_i),
            .tick_i(tick),
            .short_i(out_func_q[relay_cfg_pkg::SW_SIG_PULSE]),
            .req_i(sig_src[g]),
            .out_o(sig_str[g])
        );
    end

    // registered signal contacts
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sig_o <= 5'h00;
        end else begin
            sig_o <= sig_str;
        end
    end

    // ************************************************************
    // stage indications
    // ************************************************************
    // latched while mode 1 until unlatch, else follows start
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ind_q <= 7'h00;
        end else begin
            for (int i = 0; i < 7; i++) begin
                if (stage_start_i[i]) begin
                    ind_q[i] <= 1'b1;
                end else if (!ind_mode_q[i] || unlatch) begin
                    ind_q[i] <= 1'b0;
                end
            end
        end
    end

    assign ind_o = ind_q;

    // phase capture for stages 1, 3, 5 and 7 (indices 0, 2, 4, 6)
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            phase_q <= 12'h000;
        end else begin
            for (int j = 0; j < 4; j++) begin
                if (!ind_mode_q[2*j]) begin
                    phase_q[3*j +: 3] <= 3'h0;
                end else if (stage_start_i[2*j]) begin
                    phase_q[3*j +: 3] <= phase_q[3*j +: 3] | phase_i;
                end else if (unlatch) begin
                    phase_q[3*j +: 3] <= 3'h0;
                end
            end
        end
    end

    assign phase_show_o = phase_q;

    // ************************************************************
    // interrupts
    // ************************************************************
    // previous levels for rising edge events
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            trip_prev_q <= 3'h0;
            start_prev_q <= 7'h00;
        end else begin
            trip_prev_q <= trip_src;
            start_prev_q <= stage_start_i;
        end
    end

    // trip and start edges, breaker failure fire, warning level
    assign ev[relay_cfg_pkg::IRQ_TRIP] = |(trip_src & ~trip_prev_q);
    assign ev[relay_cfg_pkg::IRQ_BRK_FAIL] = bf_trip_q && !trip_prev_q[1];
    assign ev[relay_cfg_pkg::IRQ_START] = |(stage_start_i & ~start_prev_q);
    assign ev[relay_cfg_pkg::IRQ_WARN] = circuit_warn_i || light_warn_i;

    // sticky status, cleared by read, new event wins
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            irq_stat_q <= 4'h0;
        end else if (rd_i && addr_i == relay_cfg_pkg::ADDR_IRQ_STATUS) begin
            irq_stat_q <= ev;
        end else begin
            irq_stat_q <= irq_stat_q | ev;
        end
    end

    // level interrupt
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(irq_stat_q & irq_mask_q);
        end
    end

    // ************************************************************
    // read data
    // ************************************************************
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rdata_o <= 32'h0000_0000;
        end else if (rd_i) begin
            case (addr_i)
                relay_cfg_pkg::ADDR_OUT_FUNC:
                    rdata_o <= {24'h00_0000, out_func_q};
                relay_cfg_pkg::ADDR_IND_MODE:
                    rdata_o <= {25'h000_0000, ind_mode_q};
                relay_cfg_pkg::ADDR_IRQ_STATUS:
                    rdata_o <= {28'h000_0000, irq_stat_q};
                relay_cfg_pkg::ADDR_IRQ_MASK:
                    rdata_o <= {28'h000_0000, irq_mask_q};
                relay_cfg_pkg::ADDR_STATE: rdata_o <= {16'h0000, bf_trip_q,
                    latch_q, sig_o, ind_q};
                default: rdata_o <= 32'h0000_0000;
            endcase
        end else begin
            rdata_o <= 32'h0000_0000;
        end
    end
endmodule : relay_output_config_logic

// ===== dv/relay_output_config_logic_sva.sv
// checker: port assertions for the relay output configuration logic
`timescale 1ns/10ps
module relay_out_chk #(
    parameter int TICK_CYCLES = 4
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    // register port
    input wire logic [3:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [31:0] rdata_o,
    // requests
    input wire logic [2:0] trip_req_i,
    input wire logic lockout_req_i,
    input wire logic unlatch_panel_i,
    input wire logic unlatch_din_i,
    input wire logic unlatch_bus_i,
    input wire logic circuit_warn_i,
    input wire logic [6:0] stage_start_i,
    // contacts and indications
    input wire logic [2:0] trip_o,
    input wire logic [4:0] sig_o,
    input wire logic [6:0] ind_o
);
    logic [7:0] sw_q;
    logic [6:0] mode_q;
    logic [31:0] hi_q;
    logic sw_wr;
    logic mode_wr;
    logic unl;
    // switch writes and every unlatch source
    assign sw_wr = wr_i && addr_i == relay_cfg_pkg::ADDR_OUT_FUNC;
    assign mode_wr = wr_i && addr_i == relay_cfg_pkg::ADDR_IND_MODE;
    assign unl = unlatch_panel_i || unlatch_din_i || unlatch_bus_i
        || (wr_i && addr_i == relay_cfg_pkg::ADDR_UNLATCH && wdata_i[0]);
    // shadow switches, count closed cycles of signal output one
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sw_q <= relay_cfg_pkg::OUT_FUNC_RST;
            mode_q <= relay_cfg_pkg::IND_MODE_RST;
            hi_q <= 32'h0000_0000;
        end else begin
            if (sw_wr) begin
                sw_q <= wdata_i[7:0];
            end
            if (mode_wr) begin
                mode_q <= wdata_i[6:0];
            end
            hi_q <= sig_o[0] ? hi_q + 32'h0000_0001 : 32'h0000_0000;
        end
    end
    // ****************************************
    // properties
    // ****************************************
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!nrst_i);
    property p_rd_idle;
        !$past(rd_i) |-> rdata_o == 32'h0000_0000;
    endproperty
    property p_trip_follow;
        trip_req_i[0] |-> ##[1:2] trip_o[0];
    endproperty
    property p_trip_hold;
        sw_q[0] && trip_o[0] && !unl && !$past(unl) && !sw_wr |=> trip_o[0];
    endproperty
    property p_lockout;
        sw_q[6] && lockout_req_i |-> ##[1:2] trip_o[2];
    endproperty
    property p_ext_warn;
        sw_q[7] && circuit_warn_i |-> ##[1:2] sig_o[1];
    endproperty
    property p_ind_hold;
        mode_q[0] && ind_o[0] && !unl && !$past(unl) && !mode_wr |=> ind_o[0];
    endproperty
    property p_ind_clear;
        (!stage_start_i[0] && !mode_q[0]) [*2] |=> !ind_o[0];
    endproperty
    property p_sig_min;
        $fell(sig_o[0]) |-> hi_q >= (sw_q[3] ? 39 : 79) * TICK_CYCLES;
    endproperty
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data outside its slot");
    a_trip_follow: assert property (p_trip_follow)
        else $error("trip output did not follow its cause");
    a_trip_hold: assert property (p_trip_hold)
        else $error("latched trip output released");
    a_lockout: assert property (p_lockout)
        else $error("lockout not on third trip output");
    a_ext_warn: assert property (p_ext_warn)
        else $error("warning not on second signal output");
    a_ind_hold: assert property (p_ind_hold)
        else $error("latched indication dropped");
    a_ind_clear: assert property (p_ind_clear)
        else $error("indication stayed after fault");
    a_sig_min: assert property (p_sig_min)
        else $error("signal pulse too short");
    c_unlatch: cover property (sw_q[0] && trip_o[0] ##1 unl);
    c_lockout: cover property (sw_q[6] && lockout_req_i);
    c_ind_latch: cover property (mode_q[0] && ind_o[0] && !stage_start_i[0]);
endmodule : relay_out_chk

bind relay_output_config_logic relay_out_chk #(
    .TICK_CYCLES(TICK_CYCLES)
) i_relay_out_chk (
    .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .trip_req_i(trip_req_i), .lockout_req_i(lockout_req_i),
    .unlatch_panel_i(unlatch_panel_i), .unlatch_din_i(unlatch_din_i),
    .unlatch_bus_i(unlatch_bus_i), .circuit_warn_i(circuit_warn_i),
    .stage_start_i(stage_start_i), .trip_o(trip_o), .sig_o(sig_o),
    .ind_o(ind_o)
);

// ===== dv/relay_contacts.sv
// partner: relay contacts, measuring how long each stays closed
`timescale 1ns/10ps
module relay_contacts (
    // clock and coil drives
    input wire logic ref_clk_i,
    input wire logic trip_i,
    input wire logic sig_i,
    // closed cycles of the last pulse
    output int trip_len_o,
    output int sig_len_o
);
    int trip_run = 0;
    int sig_run = 0;
    // count closed cycles, keep the length once the contact opens
    always @(posedge ref_clk_i) begin
        trip_run <= trip_i ? trip_run + 1 : 0;
        sig_run <= sig_i ? sig_run + 1 : 0;
        if (!trip_i && trip_run != 0) trip_len_o <= trip_run;
        if (!sig_i && sig_run != 0) sig_len_o <= sig_run;
    end
endmodule : relay_contacts

// ===== dv/relay_output_config_logic_bench.sv
// testbench: register, contact and indication scenarios
`timescale 1ns/10ps
module relay_output_config_logic_bench;
    localparam int TC = 4;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [31:0] wdata = 32'h0000_0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [2:0] trip_req = 3'h0;
    logic lock = 1'b0;
    logic unl_p = 1'b0;
    logic unl_d = 1'b0;
    logic unl_b = 1'b0;
    logic [4:0] sig_req = 5'h00;
    logic cw = 1'b0;
    logic lw = 1'b0;
    logic [6:0] start = 7'h00;
    logic [2:0] phase = 3'h0;
    logic [31:0] rdata;
    logic [2:0] trip;
    logic [4:0] sig;
    logic [6:0] ind;
    logic [11:0] phs;
    logic irq;
    int tlen;
    int slen;
    int num_errors = 0;
    int n_checks = 0;
    // clock of 4 ns
    always #2 clk = ~clk;
    relay_output_config_logic #(.TICK_CYCLES(TC)) i_relay_output_config_logic (
        .ref_clk_i(clk), .nrst_i(nrst), .addr_i(addr), .wdata_i(wdata),
        .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .trip_req_i(trip_req),
        .lockout_req_i(lock), .brk_fail_ticks_i(16'h0005),
        .unlatch_panel_i(unl_p), .unlatch_din_i(unl_d), .unlatch_bus_i(unl_b),
        .sig_req_i(sig_req), .circuit_warn_i(cw), .light_warn_i(lw),
        .stage_start_i(start), .phase_i(phase), .trip_o(trip), .sig_o(sig),
        .ind_o(ind), .phase_show_o(phs), .irq_o(irq)
    );
    relay_contacts i_relay_contacts (
        .ref_clk_i(clk), .trip_i(trip[0]), .sig_i(sig[0]),
        .trip_len_o(tlen), .sig_len_o(slen)
    );
    // ****************************************
    // tasks
    // ****************************************
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc
    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        cyc(1);
    endtask : wr_reg
    task automatic rd_reg(input logic [3:0] a, input logic [31:0] exp);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(rdata, exp);
        cyc(1);
    endtask : rd_reg
    task automatic end_of_test;
        if (num_errors == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : end_of_test
    // ****************************************
    // scenarios
    // ****************************************
    initial begin
        cyc(4);
        nrst <= 1'b1;
        cyc(1);
        rd_reg(4'h0, 32'h0000_0000);
        rd_reg(4'h1, 32'h0000_0000);
        rd_reg(4'h3, 32'h0000_0000);
        wr_reg(4'h0, 32'hffff_ffa5);
        rd_reg(4'h0, 32'h0000_00a5);
        wr_reg(4'h1, 32'h0000_00ff);
        rd_reg(4'h1, 32'h0000_007f);
        wr_reg(4'h9, 32'h0000_0001);
        rd_reg(4'h9, 32'h0000_0000);
        wr_reg(4'h1, 32'h0000_0000);
        // minimum pulse lengths, long then short
        for (int k = 0; k < 2; k++) begin
            wr_reg(4'h0, k ? 32'h0000_0018 : 32'h0000_0000);
            trip_req <= 3'h1;
            sig_req <= 5'h1d;
            cyc(1);
            chk(sig, 5'h1d);
            trip_req <= 3'h0;
            sig_req <= 5'h00;
            cyc(400);
            chk(32'(tlen >= (k ? 39 : 79) * TC &&
                tlen <= (k ? 40 : 80) * TC + 3), 32'h0000_0001);
            chk(32'(slen >= (k ? 39 : 79) * TC &&
                slen <= (k ? 40 : 80) * TC + 3), 32'h0000_0001);
        end
        // latch, then release from each unlatch source
        wr_reg(4'h0, 32'h0000_0001);
        for (int s = 0; s < 4; s++) begin
            trip_req <= 3'h1;
            cyc(1);
            trip_req <= 3'h0;
            cyc(400);
            chk(trip[0], 1'b1);
            if (s == 0) begin
                rd_reg(4'h4, 32'h0000_1000);
            end
            if (s == 3) begin
                wr_reg(4'h5, 32'h0000_0001);
            end else begin
                {unl_b, unl_d, unl_p} <= 3'(3'h1 << s);
                cyc(1);
                {unl_b, unl_d, unl_p} <= 3'h0;
            end
            cyc(3);
            chk(trip[0], 1'b0);
        end
        rd_reg(4'h2, 32'h0000_0001);
        // breaker failure with masked, then unmasked interrupt
        wr_reg(4'h0, 32'h0000_0020);
        trip_req <= 3'h1;
        cyc(10);
        chk(trip[1], 1'b0);
        cyc(30);
        chk(trip[1], 1'b1);
        chk(irq, 1'b0);
        trip_req <= 3'h0;
        wr_reg(4'h3, 32'h0000_0002);
        cyc(400);
        chk(irq, 1'b1);
        rd_reg(4'h2, 32'h0000_0003);
        cyc(1);
        chk(irq, 1'b0);
        wr_reg(4'h0, 32'h0000_0000);
        trip_req <= 3'h1;
        cyc(40);
        chk(trip[1], 1'b0);
        trip_req <= 3'h0;
        cyc(400);
        rd_reg(4'h2, 32'h0000_0001);
        // lockout owns the third trip output
        wr_reg(4'h0, 32'h0000_0040);
        lock <= 1'b1;
        cyc(3);
        chk(trip[2], 1'b1);
        lock <= 1'b0;
        trip_req <= 3'h4;
        cyc(400);
        chk(trip[2], 1'b0);
        wr_reg(4'h0, 32'h0000_0000);
        cyc(3);
        chk(trip[2], 1'b1);
        trip_req <= 3'h0;
        cyc(400);
        // both warnings reach the second signal output
        for (int w = 0; w < 2; w++) begin
            {lw, cw} <= 2'(2'h1 << w);
            cyc(3);
            chk(sig[1], 1'b0);
            wr_reg(4'h0, 32'h0000_0080);
            cyc(3);
            chk(sig[1], 1'b1);
            {lw, cw} <= 2'h0;
            wr_reg(4'h0, 32'h0000_0000);
            cyc(400);
        end
        // latched indication with phases, then self-clearing
        wr_reg(4'h1, 32'h0000_0001);
        start <= 7'h01;
        phase <= 3'h5;
        cyc(3);
        start <= 7'h00;
        phase <= 3'h0;
        cyc(3);
        chk(ind[0], 1'b1);
        chk(phs[2:0], 3'h5);
        unl_p <= 1'b1;
        cyc(1);
        unl_p <= 1'b0;
        cyc(3);
        chk(ind[0], 1'b0);
        chk(phs, 12'h000);
        wr_reg(4'h1, 32'h0000_0000);
        start <= 7'h01;
        phase <= 3'h7;
        cyc(3);
        chk(ind[0], 1'b1);
        chk(phs, 12'h000);
        start <= 7'h00;
        cyc(3);
        chk(ind[0], 1'b0);
        rd_reg(4'h2, 32'h0000_000d);
        rd_reg(4'h2, 32'h0000_0000);
        // mid-run reset drops a latched trip and the switches
        wr_reg(4'h0, 32'h0000_0001);
        trip_req <= 3'h1;
        cyc(1);
        trip_req <= 3'h0;
        cyc(3);
        chk(trip[0], 1'b1);
        nrst <= 1'b0;
        cyc(2);
        chk(trip, 3'h0);
        nrst <= 1'b1;
        cyc(1);
        rd_reg(4'h0, 32'h0000_0000);
        rd_reg(4'h4, 32'h0000_0000);
        end_of_test();
    end
endmodule : relay_output_config_logic_bench
